// ===== pmc_pkg.sv
// Constants and types shared by the power mode control block
package pmc_pkg;
  // Register addresses on the special-function port
  localparam logic [7:0] PCTL_ADDR = 8'h87;
  localparam logic [7:0] AUX_ADDR  = 8'hb5;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Main power control register bit positions
  localparam int MODE_LO_BIT  = 0;
  localparam int MODE_HI_BIT  = 1;
  localparam int GFLAG_A_BIT  = 2;
  localparam int GFLAG_B_BIT  = 3;
  localparam int BO_IRQ_BIT   = 4;
  localparam int BO_OFF_BIT   = 5;
  localparam int FE_VIEW_BIT  = 6;
  localparam int BAUD_DBL_BIT = 7;

  // Auxiliary register bit positions; the rest are reserved
  localparam int UART_OFF_BIT = 1;
  localparam int I2C_OFF_BIT  = 3;
  localparam int CMP_OFF_BIT  = 5;
  localparam int RTC_OFF_BIT  = 7;
  localparam logic [7:0] AUX_MASK = 8'haa;

  // Oscillator start-up counts, in system clocks
  localparam int XTAL_START_CLKS = 1024;
  localparam int RC_START_CLKS   = 256;
  localparam int START_CNT_W     = 11;

  // Power reduction mode field encoding
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_IDLE   = 2'b01,
    MODE_PDOWN  = 2'b10,
    MODE_TOTAL  = 2'b11
  } pmc_mode_t;

  // Sequencer states, Gray along run, sleep, wake; wake to run flips both bits
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b11,
    ST_IDLE  = 2'b10
  } pmc_state_t;
endpackage

// ===== pmc_power_ctrl.sv
// Power mode control: registers, sleep sequencing, wake-up and gating
// Summary of operation
// - Total power-down is power-down plus brownout detector and comparators off.
// - Total power-down: no brownout reset/irq; comparator and brownout cannot wake.
// - Sleep stops RC oscillator unless it clocks the system and RTC runs.
// - Watchdog runs in total power-down when its clock select is 1; wakes.
// - External interrupts wake from total power-down only in level mode.
// - Keyboard and RTC wake; RTC keeps running unless its power-off bit set.
// - Mode field sits in main register bits 1:0, bit 1 high.
// - Bits 2 and 3 are free flags with no hardware effect.
// - Bit 4 selects brownout interrupt (1) or brownout reset (0).
// - Bit 5 set powers down the brownout detector.
// - Flash program or erase aborts while brownout power-down bit is 1.
// - Bit 6 selects serial bit 7 as mode bit or framing error.
// - Bit 7 passes timer 1 overflow rate; clear halves it.
// - Main register at 87h, resets to zero, normal mode.
// - Aux register at b5h: rtc 7, comparator 5, i2c 3, uart 1.
// - Mode codes: 00 normal, 01 idle, 10 power-down, 11 total power-down.
// - On wake from power-down restart oscillator, resume after 1024 crystal or 256 clocks.
// - Uart clock off when its bit set or in any power-down.
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pmc_power_ctrl #(
  parameter int XTAL_CLKS = pmc_pkg::XTAL_START_CLKS,
  parameter int RC_CLKS   = pmc_pkg::RC_START_CLKS
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        global_irq_enable,
  input  wire logic [1:0]  external_irq_inputs_n,
  input  wire logic [1:0]  ext_irq_enable,
  input  wire logic [1:0]  ext_irq_level_mode,
  input  wire logic        kbd_irq,
  input  wire logic        rtc_irq,
  input  wire logic        wdt_irq,
  input  wire logic        wdt_reset_req,
  input  wire logic        watchdog_clock_source,
  input  wire logic        comparator_irq,
  input  wire logic        brownout_detect,
  input  wire logic        rc_osc_is_sysclk,
  input  wire logic        crystal_osc_selected,
  input  wire logic        flash_cmd_req,
  input  wire logic        timer1_overflow,
  input  wire logic        serial_bit7_wr,
  input  wire logic        serial_bit7_wdata,
  input  wire logic        uart_mode_bit,
  input  wire logic        uart_framing_error,
  output logic             cpu_run,
  output logic             sys_osc_run,
  output logic             rc_osc_run,
  output logic             brownout_detector_en,
  output logic             brownout_irq,
  output logic             brownout_reset,
  output logic             comparator_power_en,
  output logic             watchdog_run,
  output logic             rtc_clock_en,
  output logic             uart_clock_en,
  output logic             i2c_clock_en,
  output logic             flash_cmd_go,
  output logic             flash_cmd_abort,
  output logic             uart_baud_tick,
  output logic             serial_bit7_rdata,
  output logic             uart_mode_bit_wr,
  output logic             uart_framing_error_wr,
  output logic             serial_bit7_wr_data
);
  pmc_wake_if wk ();

  pmc_wake_timer #(
    .XTAL_CLKS (XTAL_CLKS),
    .RC_CLKS   (RC_CLKS)
  ) u_wake_timer (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .wk      (wk)
  );

  logic [7:0]          power_control;
  logic [7:0]          power_control_aux;
  pmc_pkg::pmc_state_t state;
  pmc_pkg::pmc_state_t next_state;
  pmc_pkg::pmc_mode_t  mode;
  logic [2:0]          ext_sync;
  logic [2:0]          ext_sync_b;
  logic [1:0]          ext_level_n;
  logic [2:0]          bo_sync;
  logic                bo_level;
  logic                baud_half;
  logic                pctl_wr;
  logic                aux_wr;
  logic                sleeping;
  logic                total_mode;
  logic                bod_on;
  logic                rtc_off;
  logic [1:0]          ext_active;
  logic                ext_wake;
  logic                bo_irq_evt;
  logic                idle_wake;
  logic                sleep_wake;
  logic                wake_take;

  // Register decode
  assign pctl_wr    = reg_wr && (reg_addr == pmc_pkg::PCTL_ADDR);
  assign aux_wr     = reg_wr && (reg_addr == pmc_pkg::AUX_ADDR);
  assign mode       = pmc_pkg::pmc_mode_t'({power_control[pmc_pkg::MODE_HI_BIT],
                                            power_control[pmc_pkg::MODE_LO_BIT]});
  assign total_mode = (mode == pmc_pkg::MODE_TOTAL);
  assign sleeping   = (state == pmc_pkg::ST_SLEEP);
  assign rtc_off    = power_control_aux[pmc_pkg::RTC_OFF_BIT];
  // Detector off by its own bit or in total power-down
  assign bod_on     = !power_control[pmc_pkg::BO_OFF_BIT] && !total_mode;

  // External pins: three stages, a change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_sync    <= 3'h7;
      ext_sync_b  <= 3'h7;
      ext_level_n <= 2'h3;
    end
    else
    begin
      ext_sync    <= {ext_sync[1:0], external_irq_inputs_n[0]};
      ext_sync_b  <= {ext_sync_b[1:0], external_irq_inputs_n[1]};
      if (ext_sync[1] == ext_sync[2])
        ext_level_n[0] <= ext_sync[2];
      if (ext_sync_b[1] == ext_sync_b[2])
        ext_level_n[1] <= ext_sync_b[2];
    end
  end

  // Brownout comparator output is analog-side, filtered the same way
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bo_sync  <= 3'h0;
      bo_level <= 1'b0;
    end
    else
    begin
      bo_sync <= {bo_sync[1:0], brownout_detect};
      if (bo_sync[1] == bo_sync[2])
        bo_level <= bo_sync[2];
    end
  end

  // Wake qualification
  assign ext_active = ~ext_level_n & ext_irq_enable;
  // Edge-mode pins are not a legal wake from sleep
  assign ext_wake   = |(ext_active & ext_irq_level_mode);
  assign bo_irq_evt = bod_on && bo_level && power_control[pmc_pkg::BO_IRQ_BIT];
  assign idle_wake  = wdt_reset_req || (global_irq_enable && (|ext_active || kbd_irq
                      || rtc_irq || wdt_irq || comparator_irq || bo_irq_evt));
  // Total mode drops comparator and brownout as wake sources
  assign sleep_wake = (watchdog_clock_source && (wdt_reset_req
                      || (global_irq_enable && wdt_irq)))
                      || (global_irq_enable && (ext_wake || kbd_irq
                      || (rtc_irq && !rtc_off)))
                      || (!total_mode && global_irq_enable
                      && (comparator_irq || bo_irq_evt));
  assign wake_take  = ((state == pmc_pkg::ST_IDLE) && idle_wake)
                      || (sleeping && sleep_wake);

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      pmc_pkg::ST_RUN:
        if (mode == pmc_pkg::MODE_IDLE)
          next_state = pmc_pkg::ST_IDLE;
        else if (mode == pmc_pkg::MODE_PDOWN || total_mode)
          next_state = pmc_pkg::ST_SLEEP;
      pmc_pkg::ST_IDLE:
        if (idle_wake)
          next_state = pmc_pkg::ST_RUN;
      pmc_pkg::ST_SLEEP:
        if (sleep_wake)
          next_state = pmc_pkg::ST_WAKE;
      pmc_pkg::ST_WAKE:
        if (wk.done)
          next_state = pmc_pkg::ST_RUN;
    endcase
  end

  // Sequencer state
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= pmc_pkg::ST_RUN;
    else
      state <= next_state;
  end

  // Start the oscillator timer the cycle sleep ends
  assign wk.start   = sleeping && sleep_wake;
  assign wk.crystal = crystal_osc_selected;

  // Main power control register; software write beats the wake clear
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      power_control <= pmc_pkg::REG_RESET;
    else if (pctl_wr)
      power_control <= reg_wdata;
    else if (wake_take)
    begin
      power_control[pmc_pkg::MODE_HI_BIT] <= 1'b0;
      power_control[pmc_pkg::MODE_LO_BIT] <= 1'b0;
    end
  end

  // Auxiliary register, reserved bits held at zero
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      power_control_aux <= pmc_pkg::REG_RESET;
    else if (aux_wr)
      power_control_aux <= reg_wdata & pmc_pkg::AUX_MASK;
  end

  // Read data for one cycle only; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd && reg_addr == pmc_pkg::PCTL_ADDR)
      reg_rdata <= power_control;
    else if (reg_rd && reg_addr == pmc_pkg::AUX_ADDR)
      reg_rdata <= power_control_aux;
    else
      reg_rdata <= 8'h00;
  end

  // Clock, oscillator and analog gating outputs
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cpu_run              <= 1'b1;
      sys_osc_run          <= 1'b1;
      rc_osc_run           <= 1'b1;
      brownout_detector_en <= 1'b1;
      comparator_power_en  <= 1'b1;
      watchdog_run         <= 1'b1;
      rtc_clock_en         <= 1'b1;
      uart_clock_en        <= 1'b1;
      i2c_clock_en         <= 1'b1;
    end
    else
    begin
      cpu_run              <= (next_state == pmc_pkg::ST_RUN);
      sys_osc_run          <= !sleeping;
      rc_osc_run           <= !sleeping || (rc_osc_is_sysclk && !rtc_off);
      brownout_detector_en <= bod_on;
      comparator_power_en  <= !power_control_aux[pmc_pkg::CMP_OFF_BIT] && !total_mode;
      watchdog_run         <= !sleeping || watchdog_clock_source;
      rtc_clock_en         <= !rtc_off;
      uart_clock_en        <= !power_control_aux[pmc_pkg::UART_OFF_BIT] && !sleeping;
      i2c_clock_en         <= !power_control_aux[pmc_pkg::I2C_OFF_BIT] && !sleeping;
    end
  end

  // Brownout response: interrupt or reset, silent when detector is off
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      brownout_irq   <= 1'b0;
      brownout_reset <= 1'b0;
    end
    else
    begin
      brownout_irq   <= bo_irq_evt;
      brownout_reset <= bod_on && bo_level && !power_control[pmc_pkg::BO_IRQ_BIT];
    end
  end

  // Flash command gate, answer one cycle after the request
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flash_cmd_go    <= 1'b0;
      flash_cmd_abort <= 1'b0;
    end
    else
    begin
      flash_cmd_go    <= flash_cmd_req && !power_control[pmc_pkg::BO_OFF_BIT];
      flash_cmd_abort <= flash_cmd_req && power_control[pmc_pkg::BO_OFF_BIT];
    end
  end

  // Baud rate: pass overflows, or every second one
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      baud_half      <= 1'b0;
      uart_baud_tick <= 1'b0;
    end
    else
    begin
      if (timer1_overflow)
        baud_half <= !baud_half;
      uart_baud_tick <= timer1_overflow
                        && (power_control[pmc_pkg::BAUD_DBL_BIT] || baud_half);
    end
  end

  // Serial control bit 7 steering between mode bit and framing error
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      serial_bit7_rdata     <= 1'b0;
      uart_mode_bit_wr      <= 1'b0;
      uart_framing_error_wr <= 1'b0;
      serial_bit7_wr_data   <= 1'b0;
    end
    else
    begin
      serial_bit7_rdata     <= power_control[pmc_pkg::FE_VIEW_BIT]
                               ? uart_framing_error : uart_mode_bit;
      uart_mode_bit_wr      <= serial_bit7_wr && !power_control[pmc_pkg::FE_VIEW_BIT];
      uart_framing_error_wr <= serial_bit7_wr && power_control[pmc_pkg::FE_VIEW_BIT];
      serial_bit7_wr_data   <= serial_bit7_wdata;
    end
  end

  // Guards
  mode_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wake_take && !pctl_wr) |=> (mode == pmc_pkg::MODE_NORMAL)
                                && (cpu_run == (state == pmc_pkg::ST_RUN)))
    else $error("mode not cleared on wake");

  bod_total_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    total_mode |=> !brownout_detector_en && !comparator_power_en)
    else $error("detectors on in total power-down");

  bo_silent_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (total_mode || power_control[pmc_pkg::BO_OFF_BIT]) |=> !brownout_irq && !brownout_reset)
    else $error("brownout acted while detector off");

  rc_stop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (sleeping && !(rc_osc_is_sysclk && !rtc_off)) |=> !rc_osc_run)
    else $error("rc oscillator left running");

  wdt_wake_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (sleeping && watchdog_clock_source && wdt_reset_req) |=> state == pmc_pkg::ST_WAKE)
    else $error("watchdog reset did not wake");

  ext_edge_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (sleeping && !wdt_reset_req && !kbd_irq && !rtc_irq && !wdt_irq && !comparator_irq
     && !bo_irq_evt && ((ext_active & ext_irq_level_mode) == 2'h0)) |=> sleeping)
    else $error("woke without a valid source");

  resume_wait_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (sleeping && sleep_wake) |=> !cpu_run [*8])
    else $error("resumed before oscillator settled");

  uart_clk_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (sleeping || power_control_aux[pmc_pkg::UART_OFF_BIT]) |=> !uart_clock_en)
    else $error("uart clock not gated");

  flash_abort_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    flash_cmd_req |=> (flash_cmd_abort == $past(power_control[pmc_pkg::BO_OFF_BIT]))
                      && (flash_cmd_go != flash_cmd_abort))
    else $error("flash command gate wrong");

  baud_rate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (timer1_overflow && !power_control[pmc_pkg::BAUD_DBL_BIT] && !baud_half) |=> !uart_baud_tick)
    else $error("overflow rate not halved");
endmodule
`default_nettype wire

// ===== pmc_wake_if.sv
// Handshake between the sequencer and the oscillator start-up timer
`timescale 1ns/10ps
`default_nettype none
interface pmc_wake_if;
  logic start;
  logic crystal;
  logic busy;
  logic done;
  modport timer (input start, input crystal, output busy, output done);
  modport ctrl  (output start, output crystal, input busy, input done);
endinterface
`default_nettype wire

// ===== pmc_wake_model.sv
// Behavioural model of the core's wake-up request sources
`timescale 1ns/10ps
`default_nettype none
module pmc_wake_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       fire,
  input  wire logic [2:0] src,
  output logic            kbd_irq,
  output logic            rtc_irq,
  output logic            comparator_irq,
  output logic            wdt_irq,
  output logic [1:0]      ext_pin_n
);
  // Requests are levels held until the core side drops fire; pins idle high
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      kbd_irq        <= 1'b0;
      rtc_irq        <= 1'b0;
      comparator_irq <= 1'b0;
      wdt_irq        <= 1'b0;
      ext_pin_n      <= 2'h3;
    end
    else
    begin
      kbd_irq        <= fire && (src == 3'h0);
      rtc_irq        <= fire && (src == 3'h1);
      comparator_irq <= fire && (src == 3'h3);
      wdt_irq        <= fire && (src == 3'h4);
      // Level-held low pin; edge setups use code 5 and must not wake
      ext_pin_n[0]   <= !(fire && (src == 3'h2 || src == 3'h5));
      ext_pin_n[1]   <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== pmc_wake_timer.sv
// Oscillator start-up counter used on wake from power-down
`timescale 1ns/10ps
`default_nettype none
module pmc_wake_timer #(
  parameter int XTAL_CLKS = pmc_pkg::XTAL_START_CLKS,
  parameter int RC_CLKS   = pmc_pkg::RC_START_CLKS
) (
  input  wire logic  ref_clk,
  input  wire logic  reset_n,
  pmc_wake_if.timer  wk
);
  localparam int CW = pmc_pkg::START_CNT_W;

  initial
  begin
    if (XTAL_CLKS < 1 || RC_CLKS < 1 || XTAL_CLKS >= (1 << CW) || RC_CLKS >= (1 << CW))
      $error("start-up counts do not fit the counter");
  end

  logic [CW-1:0] cnt;

  // Count down the stabilisation time, done pulses once
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt     <= '0;
      wk.busy <= 1'b0;
      wk.done <= 1'b0;
    end
    else
    begin
      wk.done <= 1'b0;
      if (wk.start)
      begin
        wk.busy <= 1'b1;
        cnt     <= wk.crystal ? CW'(XTAL_CLKS - 1) : CW'(RC_CLKS - 1);
      end
      else if (wk.busy)
      begin
        if (cnt == '0)
        begin
          wk.busy <= 1'b0;
          wk.done <= 1'b1;
        end
        else
          cnt <= cnt - 1'b1;
      end
    end
  end

  // RC or external clock start-up takes exactly 256 clocks
  rc_startup_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wk.start && !wk.crystal) |-> ##257 wk.done)
    else $error("rc start-up count wrong");

  // Crystal start-up gives no done pulse within 8 clocks of start
  xtal_startup_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wk.start && wk.crystal) |=> !wk.done [*8])
    else $error("crystal start-up ended early");
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the power mode control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        ref_clk, reset_n, reg_wr, reg_rd, fire;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v, d;
  logic [2:0]  src_sel;
  logic [31:0] seed;
  logic        global_irq_enable, kbd_irq, rtc_irq, wdt_irq, wdt_reset_req, comparator_irq;
  logic [1:0]  ext_irq_enable, ext_irq_level_mode;
  wire  [1:0]  external_irq_inputs_n;
  logic        watchdog_clock_source, brownout_detect, rc_osc_is_sysclk, crystal_osc_selected;
  logic        flash_cmd_req, timer1_overflow, serial_bit7_wr, serial_bit7_wdata;
  logic        uart_mode_bit, uart_framing_error, cpu_run, sys_osc_run, rc_osc_run;
  logic        brownout_detector_en, brownout_irq, brownout_reset, comparator_power_en;
  logic        watchdog_run, rtc_clock_en, uart_clock_en, i2c_clock_en, flash_cmd_go;
  logic        flash_cmd_abort, uart_baud_tick, serial_bit7_rdata, uart_mode_bit_wr;
  logic        uart_framing_error_wr, serial_bit7_wr_data;
  int          error_cnt, cmp_count, n;

  pmc_power_ctrl u_pmc_power_ctrl (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .global_irq_enable, .external_irq_inputs_n, .ext_irq_enable,
    .ext_irq_level_mode, .kbd_irq, .rtc_irq, .wdt_irq, .wdt_reset_req,
    .watchdog_clock_source, .comparator_irq, .brownout_detect, .rc_osc_is_sysclk,
    .crystal_osc_selected, .flash_cmd_req, .timer1_overflow, .serial_bit7_wr,
    .serial_bit7_wdata, .uart_mode_bit, .uart_framing_error, .cpu_run, .sys_osc_run,
    .rc_osc_run, .brownout_detector_en, .brownout_irq, .brownout_reset,
    .comparator_power_en, .watchdog_run, .rtc_clock_en, .uart_clock_en, .i2c_clock_en,
    .flash_cmd_go, .flash_cmd_abort, .uart_baud_tick, .serial_bit7_rdata,
    .uart_mode_bit_wr, .uart_framing_error_wr, .serial_bit7_wr_data);

  // Far side: wake-up request sources
  pmc_wake_model u_pmc_wake_model (.ref_clk, .reset_n, .fire, .src(src_sel), .kbd_irq,
    .rtc_irq, .comparator_irq, .wdt_irq, .ext_pin_n(external_irq_inputs_n));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One-cycle strobes; read data is caught in the only cycle it stands
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] w);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] r);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    r = reg_rdata;
  endtask

  // Flash request, overflow and serial write share one pulse to save cycles
  task automatic pulse_all;
    @(posedge ref_clk);
    {flash_cmd_req, timer1_overflow, serial_bit7_wr} <= 3'h7;
    @(posedge ref_clk);
    {flash_cmd_req, timer1_overflow, serial_bit7_wr} <= 3'h0;
    #1;
  endtask

  task automatic try_wake(input logic [1:0] m, input logic [2:0] s, input logic x,
                          input logic wk, input int lo, input int hi);
    crystal_osc_selected <= x;
    watchdog_clock_source <= (s == 3'h4);
    ext_irq_level_mode <= {1'b0, s == 3'h2};
    wr_reg(pmc_pkg::PCTL_ADDR, {6'h00, m});
    repeat (3) @(posedge ref_clk);
    #1;
    check_bit("cpu_run", 1'b0, cpu_run);
    check_bit("uart_clk", m == 2'h1, uart_clock_en);
    check_bit("bo_det", m != 2'h3, brownout_detector_en);
    check_bit("cmp_pwr", m != 2'h3, comparator_power_en);
    if (m != 2'h1) check_bit("rc_osc", 1'b0, rc_osc_run);
    check_bit("wdt_run", m == 2'h1 || s == 3'h4, watchdog_run);
    check_bit("sys_osc", m == 2'h1, sys_osc_run);
    fire <= 1'b1;
    src_sel <= s;
    wdt_reset_req <= (s == 3'h4);
    n = 0;
    while (cpu_run !== 1'b1 && n < hi + 8)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check_bit("woke", wk, cpu_run === 1'b1);
    if (wk) check_bit("start_cnt", 1'b1, n >= lo && n <= hi);
    // A refused source is replaced by the keyboard to get back to run
    src_sel <= 3'h0;
    n = 0;
    while (cpu_run !== 1'b1 && n < 1200)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    fire <= 1'b0;
    wdt_reset_req <= 1'b0;
    rd_reg(pmc_pkg::PCTL_ADDR, d);
    check_byte("mode_clr", 8'h00, d);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run needs about 3000 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end

  initial
  begin
    {reset_n, reg_wr, reg_rd, fire, wdt_reset_req, brownout_detect} = 6'h0;
    {flash_cmd_req, timer1_overflow, serial_bit7_wr, serial_bit7_wdata} = 4'h0;
    {uart_mode_bit, uart_framing_error, rc_osc_is_sysclk, crystal_osc_selected} = 4'h0;
    {watchdog_clock_source, ext_irq_level_mode, src_sel} = 6'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    global_irq_enable = 1'b1;
    ext_irq_enable = 2'h3;
    error_cnt = 0;
    cmp_count = 0;
    seed = 32'h7b6f;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd_reg(pmc_pkg::PCTL_ADDR, d);
    check_byte("main_rst", 8'h00, d);
    rd_reg(pmc_pkg::AUX_ADDR, d);
    check_byte("aux_rst", 8'h00, d);
    rd_reg(8'h88, d);
    check_byte("unmapped", 8'h00, d);
    // Random register traffic with the mode field kept at normal
    repeat (16)
    begin
      seed = lfsr_next(seed);
      v = seed[7:0] & 8'hfc;
      uart_mode_bit <= seed[17];
      uart_framing_error <= seed[18];
      serial_bit7_wdata <= seed[16];
      wr_reg(pmc_pkg::PCTL_ADDR, v);
      wr_reg(pmc_pkg::AUX_ADDR, seed[15:8]);
      rd_reg(pmc_pkg::PCTL_ADDR, d);
      check_byte("main", v, d);
      rd_reg(pmc_pkg::AUX_ADDR, d);
      check_byte("aux", seed[15:8] & 8'haa, d);
      check_bit("rtc_clk", !seed[15], rtc_clock_en);
      check_bit("cmp_pwr", !seed[13], comparator_power_en);
      check_bit("i2c_clk", !seed[11], i2c_clock_en);
      check_bit("uart_clk", !seed[9], uart_clock_en);
      check_bit("bo_det", !v[5], brownout_detector_en);
      check_bit("bit7_view", v[6] ? seed[18] : seed[17], serial_bit7_rdata);
      pulse_all();
      check_bit("flash_go", !v[5], flash_cmd_go);
      check_bit("flash_abort", v[5], flash_cmd_abort);
      check_bit("mode_wr", !v[6], uart_mode_bit_wr);
      check_bit("fe_wr", v[6], uart_framing_error_wr);
      check_bit("bit7_data", seed[16], serial_bit7_wr_data);
      if (v[7]) check_bit("baud_tick", 1'b1, uart_baud_tick);
    end
    // Halved rate: two overflows give exactly one tick
    wr_reg(pmc_pkg::PCTL_ADDR, 8'h00);
    wr_reg(pmc_pkg::AUX_ADDR, 8'h00);
    n = 0;
    repeat (2)
    begin
      pulse_all();
      n += uart_baud_tick;
    end
    check_byte("half_ticks", 8'h01, n[7:0]);
    // Brownout response selection; filter needs four edges
    wr_reg(pmc_pkg::PCTL_ADDR, 8'h10);
    brownout_detect <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    check_bit("bo_irq", 1'b1, brownout_irq);
    check_bit("bo_rst", 1'b0, brownout_reset);
    wr_reg(pmc_pkg::PCTL_ADDR, 8'h00);
    repeat (3) @(posedge ref_clk);
    #1;
    check_bit("bo_rst", 1'b1, brownout_reset);
    check_bit("bo_irq", 1'b0, brownout_irq);
    wr_reg(pmc_pkg::PCTL_ADDR, 8'h20);
    repeat (3) @(posedge ref_clk);
    #1;
    check_bit("bo_off_det", 1'b0, brownout_detector_en);
    check_bit("bo_off_rst", 1'b0, brownout_reset);
    brownout_detect <= 1'b0;
    wr_reg(pmc_pkg::PCTL_ADDR, 8'h00);
    // Sleep modes against each wake source
    try_wake(2'h3, 3'h3, 1'b0, 1'b0, 0, 300);
    try_wake(2'h3, 3'h5, 1'b0, 1'b0, 0, 300);
    try_wake(2'h3, 3'h0, 1'b0, 1'b1, pmc_pkg::RC_START_CLKS, pmc_pkg::RC_START_CLKS + 14);
    try_wake(2'h2, 3'h2, 1'b1, 1'b1, pmc_pkg::XTAL_START_CLKS,
             pmc_pkg::XTAL_START_CLKS + 20);
    try_wake(2'h1, 3'h1, 1'b0, 1'b1, 1, 6);
    try_wake(2'h3, 3'h4, 1'b0, 1'b1, pmc_pkg::RC_START_CLKS, pmc_pkg::RC_START_CLKS + 14);
    summarize();
  end
endmodule
`default_nettype wire
